/* File: rtl/fsp_top.sv */
// Serial slave front end of a 2048 byte memory.
// Assumes core_clk runs well above twice the serial clock rate.
`timescale 1ns/1ps
module fsp_top (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so_data,
    output logic so_oe_n,
    output logic spi_mode_3,
    output logic selected,
    output logic write_latch
);
    import fsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [FSP_SYNC_W-1:0] meta_reg;
    logic [FSP_SYNC_W-1:0] sync_reg;
    logic sck_prev_reg;
    logic cs_prev_reg;
    logic sck_s;
    logic cs_s;
    logic si_s;
    logic hold_n_s;
    logic wp_n_s;
    fsp_state_e state_reg;
    logic cmd_read_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [2:0] obit_reg;
    logic [7:0] out_sh_reg;
    logic out_live_reg;
    logic [FSP_ADDR_W-1:0] addr_reg;
    logic wel_reg;
    logic ppe_reg;
    logic [1:0] bp_reg;
    logic mode3_reg;
    logic so_data_reg;
    logic so_oe_n_reg;
    logic sel_reg;
    logic rise_ev;
    logic fall_ev;
    logic cs_fall_ev;
    logic byte_done;
    logic [7:0] byte_in;
    logic [7:0] status_word;
    logic [7:0] out_src;
    logic in_prot;
    logic write_ok;
    logic wp_open;
    logic read_state;

    fsp_mem_if mem_bus ();

    fsp_mem #(
        .DEPTH(FSP_DEPTH)
    ) u_mem (
        .clk(core_clk),
        .bus(mem_bus.mem)
    );

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser for every pin; first stage feeds only second
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_reg <= FSP_SYNC_RST;
            sync_reg <= FSP_SYNC_RST;
        end
        else
        begin
            meta_reg <= {wp_n, hold_n, si, cs_n, sck};
            sync_reg <= meta_reg;
        end
    end

    assign sck_s = sync_reg[FSP_L_SCK];
    assign cs_s = sync_reg[FSP_L_CS];
    assign si_s = sync_reg[FSP_L_SI];
    assign hold_n_s = sync_reg[FSP_L_HOLD];
    assign wp_n_s = sync_reg[FSP_L_WP];

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sck_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b1;
        end
        else
        begin
            sck_prev_reg <= sck_s;
            cs_prev_reg <= cs_s;
        end
    end

    // Edges exist only while selected and not on hold
    assign rise_ev = sck_s & ~sck_prev_reg & hold_n_s & ~cs_s
        & (state_reg != FSP_ST_IDLE);
    assign fall_ev = ~sck_s & sck_prev_reg & hold_n_s & ~cs_s;
    assign cs_fall_ev = ~cs_s & cs_prev_reg & hold_n_s;
    assign byte_in = {shift_reg[6:0], si_s};
    assign byte_done = rise_ev && (bit_cnt_reg == FSP_LAST_BIT);
    assign status_word = {ppe_reg, 3'h0, bp_reg, wel_reg, 1'b0};
    assign wp_open = wp_n_s | ~ppe_reg;
    assign read_state = (state_reg == FSP_ST_RDATA)
        || (state_reg == FSP_ST_RSR);

    // Protected range sits at the top of the array
    always_comb
    begin
        unique case (bp_reg)
            FSP_BP_QUARTER: in_prot = (addr_reg[10:9] == FSP_TOP_QUARTER);
            FSP_BP_HALF: in_prot = addr_reg[10];
            FSP_BP_ALL: in_prot = 1'b1;
            FSP_BP_NONE: in_prot = 1'b0;
        endcase
    end

    assign write_ok = wel_reg & ~in_prot;

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer; select high wins over everything except hold
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= FSP_ST_IDLE;
            cmd_read_reg <= 1'b0;
        end
        else if (hold_n_s)
        begin
            if (cs_s)
            begin
                state_reg <= FSP_ST_IDLE;
            end
            else if (cs_fall_ev)
            begin
                state_reg <= FSP_ST_OPC;
            end
            else if (byte_done)
            begin
                unique case (state_reg)
                    FSP_ST_OPC:
                    begin
                        unique case (byte_in)
                            FSP_OP_READ:
                            begin
                                state_reg <= FSP_ST_ADDR_HI;
                                cmd_read_reg <= 1'b1;
                            end
                            FSP_OP_WRITE:
                            begin
                                state_reg <= FSP_ST_ADDR_HI;
                                cmd_read_reg <= 1'b0;
                            end
                            FSP_OP_RDSR: state_reg <= FSP_ST_RSR;
                            FSP_OP_WRSR: state_reg <= FSP_ST_WSR;
                            default: state_reg <= FSP_ST_IGNORE;
                        endcase
                    end
                    FSP_ST_ADDR_HI: state_reg <= FSP_ST_ADDR_LO;
                    FSP_ST_ADDR_LO: state_reg <= cmd_read_reg ?
                        FSP_ST_RDATA : FSP_ST_WDATA;
                    FSP_ST_WSR: state_reg <= FSP_ST_IGNORE;
                    FSP_ST_IDLE, FSP_ST_WDATA, FSP_ST_RDATA, FSP_ST_RSR,
                    FSP_ST_IGNORE: state_reg <= state_reg;
                    default: state_reg <= FSP_ST_IGNORE;
                endcase
            end
        end
    end

    // Input shifter, restarted by every select fall outside hold
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
        end
        else if (cs_fall_ev)
        begin
            bit_cnt_reg <= 3'h0;
        end
        else if (rise_ev)
        begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= byte_in;
        end
    end

    // Mode from the clock level at selection
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode3_reg <= 1'b0;
        end
        else if (cs_fall_ev)
        begin
            mode3_reg <= sck_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address: only eleven low bits are kept
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            addr_reg <= '0;
        end
        else if (byte_done && state_reg == FSP_ST_ADDR_HI)
        begin
            addr_reg[10:8] <= byte_in[2:0];
        end
        else if (byte_done && state_reg == FSP_ST_ADDR_LO)
        begin
            addr_reg[7:0] <= byte_in;
        end
        else if (byte_done && state_reg == FSP_ST_WDATA)
        begin
            addr_reg <= addr_reg + FSP_ADDR_ONE;
        end
        else if (fall_ev && state_reg == FSP_ST_RDATA && obit_reg == 3'h0)
        begin
            addr_reg <= addr_reg + FSP_ADDR_ONE;
        end
    end

    // Read of a fresh address starts on the edge that completes it
    assign mem_bus.addr = (byte_done && state_reg == FSP_ST_ADDR_LO) ?
        {addr_reg[10:8], byte_in} : addr_reg;
    assign mem_bus.wdata = byte_in;
    assign mem_bus.wr_en = byte_done && (state_reg == FSP_ST_WDATA)
        && write_ok;

    ////////////////////////////////////////////////////////////////////////
    // Write latch and status bits
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wel_reg <= 1'b0;
            ppe_reg <= 1'b0;
            bp_reg <= FSP_BP_NONE;
        end
        else if (byte_done && state_reg == FSP_ST_OPC)
        begin
            if (byte_in == FSP_OP_WREN)
            begin
                wel_reg <= 1'b1;
            end
            else if (byte_in == FSP_OP_DISABLE_WRITES)
            begin
                wel_reg <= 1'b0;
            end
        end
        else if (byte_done && state_reg == FSP_ST_WSR && wel_reg && wp_open)
        begin
            ppe_reg <= byte_in[FSP_SR_PPE];
            bp_reg <= byte_in[FSP_SR_BP_HI:FSP_SR_BP_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output shifter moves on falling edges only
    assign out_src = (state_reg == FSP_ST_RSR) ? status_word : mem_bus.rdata;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            obit_reg <= 3'h0;
            out_sh_reg <= 8'h00;
            so_data_reg <= 1'b0;
            out_live_reg <= 1'b0;
        end
        else if (cs_fall_ev)
        begin
            obit_reg <= 3'h0;
            out_live_reg <= 1'b0;
        end
        else if (fall_ev && read_state)
        begin
            obit_reg <= obit_reg + 3'h1;
            out_live_reg <= 1'b1;
            if (obit_reg == 3'h0)
            begin
                so_data_reg <= out_src[7];
                out_sh_reg <= {out_src[6:0], 1'b0};
            end
            else
            begin
                so_data_reg <= out_sh_reg[7];
                out_sh_reg <= {out_sh_reg[6:0], 1'b0};
            end
        end
    end

    // Tristate while deselected, on hold, or outside a read
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            so_oe_n_reg <= 1'b1;
            sel_reg <= 1'b0;
        end
        else
        begin
            so_oe_n_reg <= ~(hold_n_s & ~cs_s & out_live_reg
                & read_state);
            sel_reg <= (state_reg != FSP_ST_IDLE);
        end
    end

    assign so_data = so_data_reg;
    assign so_oe_n = so_oe_n_reg;
    assign spi_mode_3 = mode3_reg;
    assign selected = sel_reg;
    assign write_latch = wel_reg;

    ////////////////////////////////////////////////////////////////////////
    property p_idle_tristate;
        @(posedge core_clk) disable iff (!reset_n)
        (state_reg == FSP_ST_IDLE) |=> so_oe_n_reg;
    endproperty
    a_idle_tristate: assert property (p_idle_tristate)
        else $error("output driven while deselected");

    property p_write_on_rise;
        @(posedge core_clk) disable iff (!reset_n)
        mem_bus.wr_en |-> (sck_s && !sck_prev_reg && !cs_s);
    endproperty
    a_write_on_rise: assert property (p_write_on_rise)
        else $error("array write outside a selected rising edge");

    property p_drive_only_read;
        @(posedge core_clk) disable iff (!reset_n)
        !so_oe_n_reg |-> $past(read_state) && $past(hold_n_s);
    endproperty
    a_drive_only_read: assert property (p_drive_only_read)
        else $error("output driven outside a read");

    property p_status_guard;
        @(posedge core_clk) disable iff (!reset_n)
        (status_word[7:2] != $past(status_word[7:2])) |-> $past(wp_open);
    endproperty
    a_status_guard: assert property (p_status_guard)
        else $error("status changed while pin protection active");

    property p_hold_freeze;
        @(posedge core_clk) disable iff (!reset_n)
        !hold_n_s |=> $stable(state_reg) && $stable(bit_cnt_reg);
    endproperty
    a_hold_freeze: assert property (p_hold_freeze)
        else $error("sequencer moved while on hold");

    property p_write_advance;
        @(posedge core_clk) disable iff (!reset_n)
        mem_bus.wr_en |=>
            (addr_reg == $past(mem_bus.addr) + FSP_ADDR_ONE);
    endproperty
    a_write_advance: assert property (p_write_advance)
        else $error("address did not advance after a byte write");

    property p_write_enabled;
        @(posedge core_clk) disable iff (!reset_n)
        mem_bus.wr_en |-> wel_reg && !in_prot;
    endproperty
    a_write_enabled: assert property (p_write_enabled)
        else $error("write into protected or disabled array");

    property p_ignore_sticks;
        @(posedge core_clk) disable iff (!reset_n)
        (state_reg == FSP_ST_IGNORE) |=>
            (state_reg == FSP_ST_IGNORE || state_reg == FSP_ST_IDLE);
    endproperty
    a_ignore_sticks: assert property (p_ignore_sticks)
        else $error("left ignore state without deselect");

    property p_mode_pick;
        @(posedge core_clk) disable iff (!reset_n)
        cs_fall_ev |=> (mode3_reg == $past(sck_s)) && (bit_cnt_reg == 3'h0);
    endproperty
    a_mode_pick: assert property (p_mode_pick)
        else $error("mode not taken from clock at selection");
endmodule : fsp_top

/* File: common/fsp_pkg.sv */
// Constants for the serial memory slave front end.
// Assumes one core clock much faster than the serial clock it samples.
package fsp_pkg;
    localparam int FSP_DEPTH = 2048;
    localparam int FSP_ADDR_W = 11;
    localparam int FSP_DATA_W = 8;
    localparam int FSP_SYNC_W = 5;
    localparam logic [2:0] FSP_LAST_BIT = 3'h7;
    localparam logic [2:0] FSP_HI_ADDR_W = 3'h3;
    // Opcodes
    localparam logic [7:0] FSP_OP_WREN = 8'h06;
    localparam logic [7:0] FSP_OP_DISABLE_WRITES = 8'h04;
    localparam logic [7:0] FSP_OP_RDSR = 8'h05;
    localparam logic [7:0] FSP_OP_WRSR = 8'h01;
    localparam logic [7:0] FSP_OP_READ = 8'h03;
    localparam logic [7:0] FSP_OP_WRITE = 8'h02;
    // Status word layout
    localparam int FSP_SR_PPE = 7;
    localparam int FSP_SR_BP_HI = 3;
    localparam int FSP_SR_BP_LO = 2;
    localparam int FSP_SR_WEL = 1;
    localparam logic [1:0] FSP_BP_NONE = 2'h0;
    localparam logic [1:0] FSP_BP_QUARTER = 2'h1;
    localparam logic [1:0] FSP_BP_HALF = 2'h2;
    localparam logic [1:0] FSP_BP_ALL = 2'h3;
    localparam logic [1:0] FSP_TOP_QUARTER = 2'h3;
    localparam logic [10:0] FSP_ADDR_ONE = 11'h001;
    // Synchroniser lanes
    localparam int FSP_L_SCK = 0;
    localparam int FSP_L_CS = 1;
    localparam int FSP_L_SI = 2;
    localparam int FSP_L_HOLD = 3;
    localparam int FSP_L_WP = 4;
    // Idle pin levels, so no false clock edge follows reset
    localparam logic [4:0] FSP_SYNC_RST = 5'h1e;

    typedef enum logic [3:0] {
        FSP_ST_IDLE = 4'b0000,
        FSP_ST_OPC = 4'b0001,
        FSP_ST_ADDR_HI = 4'b0010,
        FSP_ST_ADDR_LO = 4'b0011,
        FSP_ST_WDATA = 4'b0100,
        FSP_ST_RDATA = 4'b0101,
        FSP_ST_RSR = 4'b0110,
        FSP_ST_WSR = 4'b0111,
        FSP_ST_IGNORE = 4'b1000
    } fsp_state_e;
endpackage : fsp_pkg

/* File: common/fsp_mem_if.sv */
// Port bundle between the serial front end and the byte array.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface fsp_mem_if;
    import fsp_pkg::*;
    logic wr_en;
    logic [FSP_ADDR_W-1:0] addr;
    logic [FSP_DATA_W-1:0] wdata;
    logic [FSP_DATA_W-1:0] rdata;
    modport ctrl (output wr_en, output addr, output wdata, input rdata);
    modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface : fsp_mem_if

/* File: rtl/fsp_mem.sv */
// Byte array behind the serial front end.
// Assumes write strobe and address are stable in the core clock domain.
`timescale 1ns/1ps
module fsp_mem #(
    parameter int DEPTH = fsp_pkg::FSP_DEPTH
) (
    input wire logic clk,
    fsp_mem_if.mem bus
);
    import fsp_pkg::*;

    logic [FSP_DATA_W-1:0] array_reg [DEPTH];

    // No reset: contents are meant to survive, as a nonvolatile store
    always_ff @(posedge clk)
    begin
        if (bus.wr_en)
        begin
            array_reg[bus.addr] <= bus.wdata;
        end
    end

    // Registered read, one cycle after the address
    always_ff @(posedge clk)
    begin
        bus.rdata <= array_reg[bus.addr];
    end
endmodule : fsp_mem

/* File: verification/fsp_spi_master.sv */
// Bus master model for the serial memory slave: drives the select, clock,
// data and hold pins. Assumes core_clk is the bench clock.
`timescale 1ns/1ps
module fsp_spi_master (
    input wire logic core_clk,
    input wire logic so_data,
    input wire logic so_oe_n,
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    output logic rx_valid,
    output logic [7:0] rx_byte
);
    logic m3 = 1'b0;
    int drv_seen = 0;
    // Released line reads inverted, so a stale bit never passes
    wire logic so_line = so_oe_n ? ~so_data : so_data;

    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins move 1 ns after a core edge; half period is 4 core cycles
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic start(input logic mode);
        m3 = mode;
        sck = mode;
        tick(4);
        cs_n = 1'b0;
        tick(4);
    endtask : start

    task automatic xfer(input logic [7:0] tx, input logic rx);
        logic [7:0] got = 8'h00;
        for (int i = 7; i >= 0; i--)
        begin
            sck = 1'b0;
            si = tx[i];
            tick(4);
            sck = 1'b1;
            got = {got[6:0], so_line};
            if (!so_oe_n) drv_seen++;
            tick(4);
        end
        if (rx)
        begin
            rx_byte = got;
            rx_valid = 1'b1;
            tick(1);
            rx_valid = 1'b0;
        end
    endtask : xfer

    task automatic stop();
        if (!m3)
        begin
            sck = 1'b0;
            tick(4);
        end
        cs_n = 1'b1;
        si = ~si;
        tick(8);
    endtask : stop

    // Clock and select wiggle while paused must be ignored
    task automatic pause();
        sck = 1'b0;
        tick(4);
        hold_n = 1'b0;
        tick(4);
        repeat (3)
        begin
            sck = 1'b1;
            si = ~si;
            tick(4);
            sck = 1'b0;
            tick(4);
        end
        cs_n = 1'b1;
        tick(4);
        cs_n = 1'b0;
        tick(4);
        hold_n = 1'b1;
        tick(4);
    endtask : pause
endmodule : fsp_spi_master

/* File: verification/spi_serial_fram_slave_tb.sv */
// Self-checking bench for the serial memory slave front end.
// Assumes the master model drives all serial pins; bench owns reset, wp_n.
`timescale 1ns/1ps
module spi_serial_fram_slave_tb;
    import fsp_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n;
    logic wp_n;
    wire logic sck, cs_n, si, hold_n, so_data, so_oe_n;
    wire logic mode3, sel, latch, rx_valid;
    wire logic [7:0] rx_byte;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [31:0] rng = 32'h0000df35;
    logic [7:0] shadow [0:2047];
    logic [7:0] exp_q [$];
    logic [10:0] probe [5] = '{11'h3ff, 11'h400, 11'h5ff, 11'h600, 11'h7ff};
    logic latch_m = 1'b0;
    logic ppe_m = 1'b0;
    logic [1:0] bp_m = 2'h0;

    always #10 core_clk = ~core_clk;

    fsp_top uut (.core_clk(core_clk), .reset_n(reset_n), .sck(sck),
        .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
        .so_data(so_data), .so_oe_n(so_oe_n), .spi_mode_3(mode3),
        .selected(sel), .write_latch(latch));

    fsp_spi_master m (.core_clk(core_clk), .so_data(so_data),
        .so_oe_n(so_oe_n), .sck(sck), .cs_n(cs_n), .si(si),
        .hold_n(hold_n), .rx_valid(rx_valid), .rx_byte(rx_byte));

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (err_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [7:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[7:0];
    endfunction : rnd

    function automatic logic prot(input logic [10:0] a);
        return bp_m == FSP_BP_ALL || (bp_m == FSP_BP_HALF && a[10]) ||
            (bp_m == FSP_BP_QUARTER && a[10:9] == FSP_TOP_QUARTER);
    endfunction : prot

    ////////////////////////////////////////////////////////////////////////
    task automatic hdr(input logic mode, input logic [7:0] op);
        m.start(mode);
        m.xfer(op, 1'b0);
    endtask : hdr

    task automatic cmd(input logic [7:0] op);
        hdr(1'b0, op);
        m.stop();
    endtask : cmd

    task automatic wr_sr(input logic [7:0] v);
        hdr(1'b0, FSP_OP_WRSR);
        m.xfer(v, 1'b0);
        m.stop();
        if (latch_m && !(!wp_n && ppe_m))
        begin
            ppe_m = v[7];
            bp_m = v[3:2];
        end
    endtask : wr_sr

    task automatic rd_sr();
        hdr(1'b0, FSP_OP_RDSR);
        exp_q.push_back({ppe_m, 3'h0, bp_m, latch_m, 1'b0});
        m.xfer(rnd(), 1'b1);
        m.stop();
    endtask : rd_sr

    // Burst access; shadow tracks what the array should hold
    task automatic mem(input logic rd, input logic mode,
        input logic [15:0] a, input int n, input logic hp);
        logic [10:0] p;
        logic [7:0] d;
        hdr(mode, rd ? FSP_OP_READ : FSP_OP_WRITE);
        m.xfer(a[15:8], 1'b0);
        m.xfer(a[7:0], 1'b0);
        for (int k = 0; k < n; k++)
        begin
            p = a[10:0] + k[10:0];
            d = rnd();
            if (rd) exp_q.push_back(shadow[p]);
            else if (latch_m && !prot(p)) shadow[p] = d;
            m.xfer(d, rd);
            if (hp && k == 0) m.pause();
        end
        m.stop();
    endtask : mem

    ////////////////////////////////////////////////////////////////////////
    always @(posedge rx_valid)
    begin
        if (exp_q.size() == 0)
            check("read count", 8'h00, 8'h01);
        else
            check("read byte", rx_byte, exp_q.pop_front());
    end

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            err_count++;
            final_report();
        end
    end

    initial
    begin
        reset_n = 1'b0;
        wp_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 reset_n = 1'b1;
        m.tick(4);
        check("latch", {7'h0, latch}, 8'h00);
        cmd(FSP_OP_WREN);
        latch_m = 1'b1;
        check("latch", {7'h0, latch}, 8'h01);
        // Top address bits dropped; burst wraps past the last byte
        mem(1'b0, 1'b0, 16'hf7fe, 3, 1'b0);
        mem(1'b1, 1'b1, 16'h07fe, 3, 1'b0);
        check("mode", {7'h0, mode3}, 8'h01);
        mem(1'b0, 1'b0, 16'h0123, 3, 1'b1);
        mem(1'b1, 1'b0, 16'h8123, 3, 1'b0);
        check("mode", {7'h0, mode3}, 8'h00);
        for (int b = 0; b < 4; b++)
        begin
            wr_sr({4'h0, b[1:0], 2'h0});
            rd_sr();
            foreach (probe[i])
            begin
                mem(1'b0, 1'b0, {5'h1f, probe[i]}, 1, 1'b0);
                mem(1'b1, 1'b0, {5'h00, probe[i]}, 1, 1'b0);
            end
        end
        wr_sr(8'h80);
        wp_n = 1'b0;
        wr_sr(8'h0c);
        rd_sr();
        wp_n = 1'b1;
        wr_sr(8'h00);
        rd_sr();
        m.drv_seen = 0;
        hdr(1'b0, 8'hff);
        check("select", {7'h0, sel}, 8'h01);
        m.xfer(FSP_OP_RDSR, 1'b0);
        m.xfer(rnd(), 1'b0);
        m.stop();
        check("drive count", m.drv_seen[7:0], 8'h00);
        cmd(FSP_OP_DISABLE_WRITES);
        latch_m = 1'b0;
        check("latch", {7'h0, latch}, 8'h00);
        mem(1'b0, 1'b0, 16'h0124, 1, 1'b0);
        mem(1'b1, 1'b0, 16'h0124, 1, 1'b0);
        check("tristate", {7'h0, so_oe_n}, 8'h01);
        check("select", {7'h0, sel}, 8'h00);
        final_report();
    end
endmodule : spi_serial_fram_slave_tb
